// ### vec_irq_pkg.sv
package vec_irq_pkg;

  // ----------------------------------------------------------------------
  // Register indices; the byte address on the bus is four times the index.
  // ----------------------------------------------------------------------
  localparam logic [9:0] IDX_EVT_STATUS = 10'h0f0;
  localparam logic [9:0] IDX_EVT_ENABLE = 10'h0f1;
  localparam logic [9:0] IDX_EVT_CLEAR  = 10'h0f2;
  localparam logic [9:0] IDX_PRIORITY   = 10'h0f9;
  localparam logic [9:0] IDX_PENDING    = 10'h0fa;
  localparam logic [9:0] IDX_MASK       = 10'h0fb;
  localparam logic [9:0] IDX_FLAGS      = 10'h0fc;
  localparam logic [9:0] IDX_SP_HIGH    = 10'h0fe;
  localparam logic [9:0] IDX_SP_LOW     = 10'h0ff;

  // ----------------------------------------------------------------------
  // Field positions and reset values.
  // ----------------------------------------------------------------------
  localparam int unsigned NUM_REQ        = 6;
  localparam int unsigned MASK_PROT_BIT  = 6;
  localparam int unsigned MASK_MASTER_BIT = 7;
  localparam int unsigned EVT_GRANT_BIT  = 0;
  localparam int unsigned EVT_VECTOR_BIT = 1;
  localparam int unsigned EVT_BLOCK_BIT  = 2;
  localparam logic [7:0] RST_BYTE        = 8'h00;
  localparam logic [2:0] RST_EVT         = 3'h0;

  // Upper general RAM region guarded by the protect bit.
  localparam logic [7:0] PROT_LOW_ADDR   = 8'h80;
  localparam logic [7:0] PROT_HIGH_ADDR  = 8'hef;

  // ----------------------------------------------------------------------
  // Grant sequence timing in clock periods after the sample point.
  // ----------------------------------------------------------------------
  localparam logic [5:0] PUSH_CYCLES     = 6'h30;
  localparam logic [5:0] VECTOR_CYCLES   = 6'h09;
  localparam logic [5:0] CNT_PUSH_PCL    = 6'h10;
  localparam logic [5:0] CNT_PUSH_PCH    = 6'h20;
  localparam logic [5:0] CNT_PUSH_FLAGS  = PUSH_CYCLES;
  localparam logic [5:0] CNT_RD_HIGH     = PUSH_CYCLES + 6'h01;
  localparam logic [5:0] CNT_CAP_HIGH    = PUSH_CYCLES + 6'h03;
  localparam logic [5:0] CNT_RD_LOW      = PUSH_CYCLES + 6'h05;
  localparam logic [5:0] CNT_CAP_LOW     = PUSH_CYCLES + 6'h07;
  localparam logic [5:0] CNT_FETCH       = PUSH_CYCLES + VECTOR_CYCLES;

  typedef enum logic [0:0] {SEQ_IDLE, SEQ_RUN} seq_state_e;

endpackage : vec_irq_pkg

// ### request_priority_picker.sv
// ------------------------------------------------------------------------
// Rotating priority encoder over the enabled pending requests.
// ------------------------------------------------------------------------
module request_priority_picker
  import vec_irq_pkg::*;
#(
  parameter int unsigned N = NUM_REQ
) (
  // Requests and programmed order.
  input  wire logic [N-1:0] active_i,
  input  wire logic [2:0]   first_i,
  // Winner.
  output logic              valid_o,
  output logic [2:0]        index_o
);

  // The search starts at first_i and wraps; an out-of-range start acts as 0.
  always_comb begin
    int unsigned start;
    int unsigned k;
    start   = (32'(first_i) < N) ? 32'(first_i) : 0;
    k       = 0;
    valid_o = 1'b0;
    index_o = 3'h0;
    for (int unsigned i = 0; i < N; i++) begin
      k = (start + i) % N;
      if (!valid_o && active_i[k]) begin
        valid_o = 1'b1;
        index_o = 3'(k);
      end
    end
  end

endmodule // request_priority_picker

// ### vectored_interrupt_unit.sv
// Summary of operation
// - Six maskable, prioritised requests are fed from eight sources.
// - Four port-3 pins, serial receive, serial transmit and two timers.
// - Mask enables requests one by one, or all together.
// - Mask bits 0..5 enable requests 0..5 in order.
// - Several pending requests are resolved by a software-programmed priority register.
// - Program memory bytes 0..11 hold six 16-bit vectors.
// - A grant disables interrupts, pushes PC and flags, then branches via vector.
// - Vector byte and next byte form the 16-bit service routine address.
// - Pending register stays readable while requests are masked.
// - Software writing one to a pending bit raises that request.
// - Requests are sampled only at the last cycle of each instruction.
// - Forty-eight cycles after sampling cover priority and three stack pushes.
// - The next nine cycles fetch the vector from external memory.
// - Service routine fetch begins on the 58th period after the sample.
// - Mask bit 6 blocks access to upper general RAM; clearing it lifts this.
// - Pushes use a 16-bit stack address from the high and low pointers.
module vectored_interrupt_unit
  import vec_irq_pkg::*;
(
  // Clock and reset.
  input  wire logic        ref_clk_i,
  input  wire logic        reset_i,
  // APB slave.
  input  wire logic        psel_i,
  input  wire logic        penable_i,
  input  wire logic        pwrite_i,
  input  wire logic [11:0] paddr_i,
  input  wire logic [31:0] pwdata_i,
  output logic [31:0]      prdata_o,
  output logic             pready_o,
  output logic             pslverr_o,
  // Request sources.
  input  wire logic [3:0]  port3_request_inputs_i,
  input  wire logic        serial_rx_done_i,
  input  wire logic        serial_tx_done_i,
  input  wire logic [1:0]  timer_done_i,
  // Core sequencer side.
  input  wire logic        instr_last_cycle_i,
  input  wire logic [15:0] pc_i,
  output logic             grant_busy_o,
  output logic             isr_fetch_o,
  output logic [15:0]      isr_addr_o,
  // Stack pushes.
  output logic             stack_wr_o,
  output logic [15:0]      stack_addr_o,
  output logic [7:0]       stack_data_o,
  // Program memory vector reads; data is due in the cycle after the strobe.
  output logic             mem_rd_o,
  output logic [15:0]      mem_addr_o,
  input  wire logic [7:0]  mem_data_i,
  // RAM protect check.
  input  wire logic        ram_access_i,
  input  wire logic [7:0]  ram_addr_i,
  output logic             ram_blocked_o,
  // Interrupt line.
  output logic             irq_o
);

  // ----------------------------------------------------------------------
  // Storage.
  // ----------------------------------------------------------------------
  logic [5:0]  pending_ff;
  logic [7:0]  mask_ff;
  logic [7:0]  flags_ff;
  logic [2:0]  prio_ff;
  logic [7:0]  sph_ff;
  logic [7:0]  spl_ff;
  logic [2:0]  evt_status_ff;
  logic [2:0]  evt_enable_ff;
  logic [3:0]  pin_lvl_ff;
  logic [3:0]  pin_fall;
  logic [5:0]  hw_req;
  logic        pick_valid;
  logic [2:0]  pick_idx;
  logic [2:0]  win_idx_ff;
  logic [15:0] pc_ff;
  logic [7:0]  vec_high_ff;
  logic [7:0]  vec_low_ff;
  logic [5:0]  seq_cnt_ff;
  seq_state_e  seq_state_ff;
  logic        sample;
  logic        acc_phase;
  logic        wr_done;
  logic [9:0]  reg_idx;
  logic        mapped;
  logic [7:0]  rd_byte;
  logic [2:0]  evt_set;
  logic [15:0] sp_cur;
  logic [15:0] nxt_sp;

  // ----------------------------------------------------------------------
  // Pin synchronisers with two-stage agreement; pins signal active low.
  // ----------------------------------------------------------------------
  generate
    for (genvar g = 0; g < 4; g++) begin : g_pin
      logic [2:0] sync_ff;
      // The third stage only confirms; a change counts when stages agree.
      always_ff @(posedge ref_clk_i or posedge reset_i) begin
        if (reset_i) begin
          sync_ff       <= 3'h7;
          pin_lvl_ff[g] <= 1'b1;
        end else begin
          sync_ff <= {sync_ff[1:0], port3_request_inputs_i[g]};
          if (sync_ff[1] == sync_ff[2]) begin
            pin_lvl_ff[g] <= sync_ff[2];
          end
        end
      end
      assign pin_fall[g] = pin_lvl_ff[g] && (g_pin[g].sync_ff[1] == g_pin[g].sync_ff[2]) && !sync_ff[2];
    end
  endgenerate

  // Eight sources folded onto six requests; shared lines are ORed.
  assign hw_req = {timer_done_i[1],
                   timer_done_i[0] | serial_tx_done_i,
                   pin_fall[0] | serial_rx_done_i,
                   pin_fall[1], pin_fall[3], pin_fall[2]};

  // ----------------------------------------------------------------------
  // Priority resolution.
  // ----------------------------------------------------------------------
  request_priority_picker #(
    .N (NUM_REQ)
  ) u_picker (
    .active_i (pending_ff & mask_ff[5:0]),
    .first_i  (prio_ff),
    .valid_o  (pick_valid),
    .index_o  (pick_idx)
  );

  // A grant starts only at an instruction end, with the master enable on.
  assign sample = instr_last_cycle_i && (seq_state_ff == SEQ_IDLE)
                  && mask_ff[MASK_MASTER_BIT] && pick_valid;

  // ----------------------------------------------------------------------
  // APB decode; every access has one wait state.
  // ----------------------------------------------------------------------
  assign acc_phase = psel_i && penable_i;
  assign wr_done   = acc_phase && pwrite_i && pready_o;
  assign reg_idx   = paddr_i[11:2];
  assign mapped    = (reg_idx inside {IDX_EVT_STATUS, IDX_EVT_ENABLE, IDX_EVT_CLEAR,
                      IDX_PRIORITY, IDX_PENDING, IDX_MASK, IDX_FLAGS,
                      IDX_SP_HIGH, IDX_SP_LOW});

  // Read mux; the clear register and unmapped words read as zero.
  always_comb begin
    case (reg_idx)
      IDX_EVT_STATUS: rd_byte = {5'h00, evt_status_ff};
      IDX_EVT_ENABLE: rd_byte = {5'h00, evt_enable_ff};
      IDX_PRIORITY:   rd_byte = {5'h00, prio_ff};
      IDX_PENDING:    rd_byte = {2'h0, pending_ff};
      IDX_MASK:       rd_byte = mask_ff;
      IDX_FLAGS:      rd_byte = flags_ff;
      IDX_SP_HIGH:    rd_byte = sph_ff;
      IDX_SP_LOW:     rd_byte = spl_ff;
      default:        rd_byte = 8'h00;
    endcase
  end

  // Ready rises one cycle into the access phase and falls after completion.
  always_ff @(posedge ref_clk_i or posedge reset_i) begin
    if (reset_i) begin
      pready_o  <= 1'b0;
      prdata_o  <= 32'h0000_0000;
      pslverr_o <= 1'b0;
    end else if (acc_phase && !pready_o) begin
      pready_o  <= 1'b1;
      prdata_o  <= pwrite_i ? 32'h0000_0000 : {24'h00_0000, rd_byte};
      pslverr_o <= !mapped;
    end else begin
      pready_o  <= 1'b0;
      pslverr_o <= 1'b0;
    end
  end

  // ----------------------------------------------------------------------
  // Pending, mask, priority and flags registers.
  // ----------------------------------------------------------------------
  // A source pulse in the same cycle as a write or a grant clear still lands.
  always_ff @(posedge ref_clk_i or posedge reset_i) begin
    if (reset_i) begin
      pending_ff <= 6'h00;
    end else begin
      logic [5:0] nxt_pending;
      nxt_pending = pending_ff;
      if (wr_done && reg_idx == IDX_PENDING) begin
        nxt_pending = pwdata_i[5:0];
      end
      if (sample) begin
        nxt_pending[pick_idx] = 1'b0;
      end
      pending_ff <= nxt_pending | hw_req;
    end
  end

  // The grant drops the master enable; it wins over a same-cycle write.
  always_ff @(posedge ref_clk_i or posedge reset_i) begin
    if (reset_i) begin
      mask_ff  <= RST_BYTE;
      prio_ff  <= 3'h0;
      flags_ff <= RST_BYTE;
    end else begin
      if (wr_done && reg_idx == IDX_MASK) begin
        mask_ff <= pwdata_i[7:0];
      end
      if (sample) begin
        mask_ff[MASK_MASTER_BIT] <= 1'b0;
      end
      if (wr_done && reg_idx == IDX_PRIORITY) begin
        prio_ff <= pwdata_i[2:0];
      end
      if (wr_done && reg_idx == IDX_FLAGS) begin
        flags_ff <= pwdata_i[7:0];
      end
    end
  end

  // ----------------------------------------------------------------------
  // Stack pointer; pushes pre-decrement and override software writes.
  // ----------------------------------------------------------------------
  assign sp_cur = {sph_ff, spl_ff};
  assign nxt_sp = sp_cur - 16'h0001;

  always_ff @(posedge ref_clk_i or posedge reset_i) begin
    if (reset_i) begin
      sph_ff <= RST_BYTE;
      spl_ff <= RST_BYTE;
    end else if (seq_state_ff == SEQ_RUN && (seq_cnt_ff == CNT_PUSH_PCL
                 || seq_cnt_ff == CNT_PUSH_PCH || seq_cnt_ff == CNT_PUSH_FLAGS)) begin
      {sph_ff, spl_ff} <= nxt_sp;
    end else if (wr_done && reg_idx == IDX_SP_HIGH) begin
      sph_ff <= pwdata_i[7:0];
    end else if (wr_done && reg_idx == IDX_SP_LOW) begin
      spl_ff <= pwdata_i[7:0];
    end
  end

  // ----------------------------------------------------------------------
  // Grant sequence: 48 cycles of pushes, nine of vector fetch, then branch.
  // ----------------------------------------------------------------------
  always_ff @(posedge ref_clk_i or posedge reset_i) begin
    if (reset_i) begin
      seq_state_ff <= SEQ_IDLE;
      seq_cnt_ff   <= 6'h00;
      win_idx_ff   <= 3'h0;
      pc_ff        <= 16'h0000;
    end else begin
      case (seq_state_ff)
        SEQ_IDLE: begin
          if (sample) begin
            seq_state_ff <= SEQ_RUN;
            seq_cnt_ff   <= 6'h01;
            win_idx_ff   <= pick_idx;
            pc_ff        <= pc_i;
          end
        end
        SEQ_RUN: begin
          seq_cnt_ff <= seq_cnt_ff + 6'h01;
          if (seq_cnt_ff == CNT_FETCH) begin
            seq_state_ff <= SEQ_IDLE;
            seq_cnt_ff   <= 6'h00;
          end
        end
        default: begin
          seq_state_ff <= SEQ_IDLE;
        end
      endcase
    end
  end

  // Push low PC byte, high PC byte, then flags, each at its own slot.
  always_ff @(posedge ref_clk_i or posedge reset_i) begin
    if (reset_i) begin
      stack_wr_o   <= 1'b0;
      stack_addr_o <= 16'h0000;
      stack_data_o <= 8'h00;
    end else begin
      stack_wr_o <= 1'b0;
      if (seq_state_ff == SEQ_RUN) begin
        if (seq_cnt_ff == CNT_PUSH_PCL || seq_cnt_ff == CNT_PUSH_PCH
            || seq_cnt_ff == CNT_PUSH_FLAGS) begin
          stack_wr_o   <= 1'b1;
          stack_addr_o <= nxt_sp;
        end
        if (seq_cnt_ff == CNT_PUSH_PCL) begin
          stack_data_o <= pc_ff[7:0];
        end else if (seq_cnt_ff == CNT_PUSH_PCH) begin
          stack_data_o <= pc_ff[15:8];
        end else if (seq_cnt_ff == CNT_PUSH_FLAGS) begin
          stack_data_o <= flags_ff;
        end
      end
    end
  end

  // Vector pair at 2*n and 2*n+1 inside the low twelve bytes; high byte first.
  always_ff @(posedge ref_clk_i or posedge reset_i) begin
    if (reset_i) begin
      mem_rd_o    <= 1'b0;
      mem_addr_o  <= 16'h0000;
      vec_high_ff <= 8'h00;
      vec_low_ff  <= 8'h00;
    end else begin
      mem_rd_o <= 1'b0;
      if (seq_state_ff == SEQ_RUN) begin
        if (seq_cnt_ff == CNT_RD_HIGH) begin
          mem_rd_o   <= 1'b1;
          mem_addr_o <= {12'h000, win_idx_ff, 1'b0};
        end
        if (seq_cnt_ff == CNT_RD_LOW) begin
          mem_rd_o   <= 1'b1;
          mem_addr_o <= {12'h000, win_idx_ff, 1'b1};
        end
        if (seq_cnt_ff == CNT_CAP_HIGH) begin
          vec_high_ff <= mem_data_i;
        end
        if (seq_cnt_ff == CNT_CAP_LOW) begin
          vec_low_ff <= mem_data_i;
        end
      end
    end
  end

  // Branch strobe and busy level toward the core.
  always_ff @(posedge ref_clk_i or posedge reset_i) begin
    if (reset_i) begin
      isr_fetch_o  <= 1'b0;
      isr_addr_o   <= 16'h0000;
      grant_busy_o <= 1'b0;
    end else begin
      isr_fetch_o  <= (seq_state_ff == SEQ_RUN) && (seq_cnt_ff == CNT_FETCH);
      grant_busy_o <= sample || (seq_state_ff == SEQ_RUN && seq_cnt_ff != CNT_FETCH);
      if (seq_state_ff == SEQ_RUN && seq_cnt_ff == CNT_FETCH) begin
        isr_addr_o <= {vec_high_ff, vec_low_ff};
      end
    end
  end

  // ----------------------------------------------------------------------
  // RAM protect and event interrupt.
  // ----------------------------------------------------------------------
  always_ff @(posedge ref_clk_i or posedge reset_i) begin
    if (reset_i) begin
      ram_blocked_o <= 1'b0;
    end else begin
      ram_blocked_o <= ram_access_i && mask_ff[MASK_PROT_BIT]
                       && ram_addr_i >= PROT_LOW_ADDR && ram_addr_i <= PROT_HIGH_ADDR;
    end
  end

  assign evt_set = {ram_access_i && mask_ff[MASK_PROT_BIT] && ram_addr_i >= PROT_LOW_ADDR
                    && ram_addr_i <= PROT_HIGH_ADDR,
                    seq_state_ff == SEQ_RUN && seq_cnt_ff == CNT_FETCH, sample};

  // Sticky events; a new event beats a same-cycle clear.
  always_ff @(posedge ref_clk_i or posedge reset_i) begin
    if (reset_i) begin
      evt_status_ff <= RST_EVT;
      evt_enable_ff <= RST_EVT;
      irq_o         <= 1'b0;
    end else begin
      if (wr_done && reg_idx == IDX_EVT_CLEAR) begin
        evt_status_ff <= (evt_status_ff & ~pwdata_i[2:0]) | evt_set;
      end else begin
        evt_status_ff <= evt_status_ff | evt_set;
      end
      if (wr_done && reg_idx == IDX_EVT_ENABLE) begin
        evt_enable_ff <= pwdata_i[2:0];
      end
      irq_o <= |(evt_status_ff & evt_enable_ff);
    end
  end

  // ----------------------------------------------------------------------
  // Checks.
  // ----------------------------------------------------------------------
  sequence s_pushes;
    ##CNT_PUSH_PCL stack_wr_o ##16 stack_wr_o ##16 stack_wr_o;
  endsequence

  sequence s_vector_reads;
    ##2 mem_rd_o && mem_addr_o[0] == 1'b0 ##4 mem_rd_o && mem_addr_o[0] == 1'b1;
  endsequence

  property p_push_slots;
    @(posedge ref_clk_i) disable iff (reset_i) sample |-> ##1 s_pushes;
  endproperty
  a_push_slots: assert property (p_push_slots) else $error("push slots wrong");

  property p_vector_reads;
    @(posedge ref_clk_i) disable iff (reset_i)
      sample |-> ##48 s_vector_reads;
  endproperty
  a_vector_reads: assert property (p_vector_reads) else $error("vector reads wrong");

  property p_fetch_time;
    @(posedge ref_clk_i) disable iff (reset_i) sample |-> !isr_fetch_o [*8] ##51 isr_fetch_o;
  endproperty
  a_fetch_time: assert property (p_fetch_time) else $error("fetch not at 58th period");

  property p_master_off;
    @(posedge ref_clk_i) disable iff (reset_i) sample |=> !mask_ff[MASK_MASTER_BIT];
  endproperty
  a_master_off: assert property (p_master_off) else $error("master enable kept");

  property p_no_grant_disabled;
    @(posedge ref_clk_i) disable iff (reset_i)
      (seq_state_ff == SEQ_IDLE && !mask_ff[MASK_MASTER_BIT]) |=> seq_state_ff == SEQ_IDLE;
  endproperty
  a_no_grant_disabled: assert property (p_no_grant_disabled) else $error("grant while off");

  property p_sample_point;
    @(posedge ref_clk_i) disable iff (reset_i)
      (seq_state_ff == SEQ_IDLE && !instr_last_cycle_i) |=> seq_state_ff == SEQ_IDLE;
  endproperty
  a_sample_point: assert property (p_sample_point) else $error("sampled mid instruction");

  property p_stack_addr;
    @(posedge ref_clk_i) disable iff (reset_i) stack_wr_o |-> stack_addr_o == {sph_ff, spl_ff};
  endproperty
  a_stack_addr: assert property (p_stack_addr) else $error("stack address mismatch");

  property p_ram_block;
    @(posedge ref_clk_i) disable iff (reset_i)
      (ram_access_i && !mask_ff[MASK_PROT_BIT]) |=> !ram_blocked_o;
  endproperty
  a_ram_block: assert property (p_ram_block) else $error("blocked without protect");

  property p_vector_addr;
    @(posedge ref_clk_i) disable iff (reset_i) mem_rd_o |-> mem_addr_o < 16'h000c;
  endproperty
  a_vector_addr: assert property (p_vector_addr) else $error("vector outside table");

endmodule // vectored_interrupt_unit

// ### vec_mem_model.sv
module vec_mem_model (
  // Clock.
  input  wire logic        ref_clk_i,
  // Vector reads from the block.
  input  wire logic        mem_rd_i,
  input  wire logic [15:0] mem_addr_i,
  output logic [7:0]       mem_data_o
);
  timeunit 1ns;
  timeprecision 1ns;
  // ------------------------------------------------------------
  // External program memory holding the vector table.
  // ------------------------------------------------------------
  initial mem_data_o = 8'h00;
  // Data follows a read strobe by one cycle; otherwise the bus flips
  // every cycle so that a late capture never sees a stale byte.
  always @(posedge ref_clk_i) begin
    if (mem_rd_i) mem_data_o <= mem_addr_i[7:0] ^ 8'h5a;
    else mem_data_o <= ~mem_data_o;
  end
endmodule // vec_mem_model

// ### vectored_interrupt_unit_tb.sv
module vectored_interrupt_unit_tb;
  timeunit 1ns;
  timeprecision 1ns;
  import vec_irq_pkg::*;
  // ------------------------------------------------------------
  // Stimulus, design and memory partner.
  // ------------------------------------------------------------
  logic        clk = 1'b0, rst = 1'b1, psel = 1'b0, pen = 1'b0, pwr = 1'b0;
  logic        ilast = 1'b0, rx = 1'b0, tx = 1'b0, racc = 1'b0, err;
  logic [1:0]  tmr = 2'h0;
  logic [3:0]  pins = 4'hf;
  logic [7:0]  raddr = 8'h00, mdata, sdata;
  logic [11:0] paddr = 12'h000;
  logic [15:0] pc = 16'hbeef, sp, isr, saddr, maddr;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic        pready, pslverr, busy, fetch, swr, mrd, blk, irq;
  int          n_fail = 0, check_count = 0, cyc = 0;
  int          srcbit[6] = '{4, 5, 3, 4, 0, 2};

  vectored_interrupt_unit dut_u (.ref_clk_i(clk), .reset_i(rst), .psel_i(psel), .penable_i(pen),
    .pwrite_i(pwr), .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata), .pready_o(pready),
    .pslverr_o(pslverr), .port3_request_inputs_i(pins), .serial_rx_done_i(rx),
    .serial_tx_done_i(tx), .timer_done_i(tmr), .instr_last_cycle_i(ilast), .pc_i(pc),
    .grant_busy_o(busy), .isr_fetch_o(fetch), .isr_addr_o(isr), .stack_wr_o(swr),
    .stack_addr_o(saddr), .stack_data_o(sdata), .mem_rd_o(mrd), .mem_addr_o(maddr),
    .mem_data_i(mdata), .ram_access_i(racc), .ram_addr_i(raddr), .ram_blocked_o(blk), .irq_o(irq));
  vec_mem_model mem_u (.ref_clk_i(clk), .mem_rd_i(mrd), .mem_addr_i(maddr), .mem_data_o(mdata));

  // Free-running clock and a cycle ceiling that cuts a hang short.
  initial forever #20 clk = ~clk;
  always @(posedge clk) begin
    cyc++;
    if (cyc == 5000) begin
      n_fail++;
      complete_run();
    end
  end

  task automatic complete_run();
    $display("checks %0d mismatches %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    check_count++;
    if (got !== exp) begin
      $display("mismatch %s expected %h seen %h", what, exp, got);
      n_fail++;
    end
  endtask

  // One APB transfer; the wait has no bound of its own, the ceiling ends it.
  task automatic apb(input logic wr, input logic [9:0] idx, input logic [31:0] wd);
    @(posedge clk);
    psel   <= 1'b1;
    pwr    <= wr;
    paddr  <= {idx, 2'b00};
    pwdata <= wd;
    @(posedge clk);
    pen <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    rd  = prdata;
    err = pslverr;
    psel <= 1'b0;
    pen  <= 1'b0;
  endtask

  task automatic rdc(input string what, input logic [9:0] idx, input logic [31:0] exp);
    apb(1'b0, idx, 32'h0);
    chk(what, exp, rd);
  endtask

  // Raises the sample point once and times every step of the grant.
  task automatic grant(input int n, input logic [7:0] flags);
    int sw, mr, fc;
    logic [23:0] push;
    sw = 0;
    mr = 0;
    fc = 0;
    push = {flags, pc};
    ilast <= 1'b1;
    @(posedge clk);
    ilast <= 1'b0;
    for (int k = 1; k <= 60; k++) begin
      @(posedge clk);
      if (k == 30 || k == 60) chk("busy", k == 30, busy);
      if (swr === 1'b1) begin
        chk("push_time", 17 + 16 * sw, k);
        chk("push_addr", sp - 16'(sw + 1), saddr);
        chk("push_data", push[8*sw +: 8], sdata);
        sw++;
      end
      if (mrd === 1'b1) begin
        chk("vec_time", 50 + 4 * mr, k);
        chk("vec_addr", 2 * n + mr, maddr);
        mr++;
      end
      if (fetch === 1'b1) begin
        chk("fetch_time", 58, k);
        chk("isr_addr", {8'(2 * n) ^ 8'h5a, 8'(2 * n + 1) ^ 8'h5a}, isr);
        fc++;
      end
    end
    chk("counts", 12'h321, {sw[3:0], mr[3:0], fc[3:0]});
    sp = sp - 16'h3;
  endtask

  // Main sequence of tests.
  initial begin
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    rdc("mask_rst", IDX_MASK, 32'h0);
    rdc("pend_rst", IDX_PENDING, 32'h0);
    apb(1'b0, 10'h0f3, 32'h0);
    chk("unmapped", 1'b1, err);
    $display("test reset done");
    for (int i = 0; i < 6; i++) begin
      apb(1'b1, IDX_PENDING, 32'h0);
      case (i)
        0: tmr <= 2'h1;
        1: tmr <= 2'h2;
        2: rx <= 1'b1;
        3: tx <= 1'b1;
        4: pins <= 4'hb;
        default: pins <= 4'hd;
      endcase
      @(posedge clk);
      {tmr, rx, tx} <= 4'h0;
      // Pins pass a three-stage filter, so a low must stand for several cycles.
      repeat (5) @(posedge clk);
      pins <= 4'hf;
      rdc("source", IDX_PENDING, 32'h1 << srcbit[i]);
    end
    $display("test sources done");
    // Master enable off: the sample point must be ignored.
    apb(1'b1, IDX_PENDING, 32'h12);
    apb(1'b1, IDX_MASK, 32'h3f);
    ilast <= 1'b1;
    @(posedge clk);
    ilast <= 1'b0;
    repeat (3) @(posedge clk);
    chk("no_grant", 1'b0, busy);
    rdc("poll", IDX_PENDING, 32'h12);
    $display("test polling done");
    apb(1'b1, IDX_SP_HIGH, 32'h12);
    apb(1'b1, IDX_SP_LOW, 32'h40);
    apb(1'b1, IDX_FLAGS, 32'ha5);
    apb(1'b1, IDX_PRIORITY, 32'h3);
    apb(1'b1, IDX_EVT_ENABLE, 32'h1);
    apb(1'b1, IDX_MASK, 32'hbf);
    sp = 16'h1240;
    grant(4, 8'ha5);
    rdc("pend_clr", IDX_PENDING, 32'h02);
    rdc("master_off", IDX_MASK, 32'h3f);
    chk("irq_set", 1'b1, irq);
    rdc("status", IDX_EVT_STATUS, 32'h3);
    apb(1'b1, IDX_EVT_ENABLE, 32'h0);
    repeat (2) @(posedge clk);
    chk("irq_mask", 1'b0, irq);
    apb(1'b1, IDX_EVT_CLEAR, 32'h7);
    rdc("status_clr", IDX_EVT_STATUS, 32'h0);
    // Request 0 ranks first after 5 but is masked off individually.
    apb(1'b1, IDX_PENDING, 32'h03);
    apb(1'b1, IDX_FLAGS, 32'h5a);
    apb(1'b1, IDX_PRIORITY, 32'h5);
    apb(1'b1, IDX_MASK, 32'h82);
    grant(1, 8'h5a);
    rdc("pend_left", IDX_PENDING, 32'h01);
    $display("test grants done");
    for (int i = 0; i < 3; i++) begin
      apb(1'b1, IDX_MASK, {25'h0, i != 2, 6'h0});
      racc  <= 1'b1;
      raddr <= (i == 1) ? 8'h7f : 8'h90;
      @(posedge clk);
      racc <= 1'b0;
      @(posedge clk);
      chk("ram_block", i == 0, blk);
    end
    rdc("status_blk", IDX_EVT_STATUS, 32'h7);
    $display("test protect done");
    complete_run();
  end
endmodule // vectored_interrupt_unit_tb
